// File: logic/drdt_pkg.sv
// Purpose: shared constants of the dual reload down timer
// Assumes: 8-bit register data, 4-bit register address
// Notes:   offsets index 8-bit registers on the plain register port
package drdt_pkg;
   localparam int unsigned DW = 8;
   localparam int unsigned AW = 4;

   // register offsets
   localparam logic [AW-1:0] ADR_CTRL    = 4'h0;
   localparam logic [AW-1:0] ADR_CFG0    = 4'h1;
   localparam logic [AW-1:0] ADR_CFG1    = 4'h2;
   localparam logic [AW-1:0] ADR_RELOAD0 = 4'h3;
   localparam logic [AW-1:0] ADR_RELOAD1 = 4'h4;
   localparam logic [AW-1:0] ADR_COUNT0  = 4'h5;
   localparam logic [AW-1:0] ADR_COUNT1  = 4'h6;
   localparam logic [AW-1:0] ADR_IRQ     = 4'h7;

   // control register fields
   localparam int unsigned B_T0_RUN    = 0;
   localparam int unsigned B_T1_RUN    = 1;
   localparam int unsigned B_T0_PRESET = 2;
   localparam int unsigned B_T1_PRESET = 3;
   localparam int unsigned B_CHAIN     = 4;
   localparam int unsigned B_PULSE_OUTPUT_CH   = 5;
   localparam int unsigned B_PULSE_OUTPUT_EN   = 6;

   // configuration fields (ratio in bits 1:0)
   localparam int unsigned B_RATIO_LO  = 0;
   localparam int unsigned B_RATIO_HI  = 1;
   localparam int unsigned B_SRC_SEL   = 2;
   localparam int unsigned B_CNT_SRC   = 3;
   localparam int unsigned B_EDGE_POL  = 4;
   localparam int unsigned B_FILTER    = 5;

   // interrupt register fields
   localparam int unsigned B_T0_FLAG   = 0;
   localparam int unsigned B_T1_FLAG   = 1;
   localparam int unsigned B_T0_MASK   = 2;
   localparam int unsigned B_T1_MASK   = 3;

   // values after reset
   localparam logic [DW-1:0] RST_REG   = 8'h00;
   localparam logic [DW-1:0] RST_COUNT = 8'h00;

   // prescaler ratio codes: /1, /4, /32, /256
   localparam logic [7:0] DIV_MASK_0 = 8'h00;
   localparam logic [7:0] DIV_MASK_1 = 8'h03;
   localparam logic [7:0] DIV_MASK_2 = 8'h1F;
   localparam logic [7:0] DIV_MASK_3 = 8'hFF;

   // noise rejector timing
   localparam int unsigned OSC1_HZ      = 32768;
   localparam int unsigned F2K_HZ       = 2048;
   localparam int unsigned F2K_DIV      = OSC1_HZ / F2K_HZ;
   localparam int unsigned FILTER_FALLS = 2;
   localparam int unsigned REJECT_US    = 480;
   localparam int unsigned MIN_PULSE_US = 980;
endpackage

// File: logic/drdt_prescaler.sv
// Purpose: per-timer prescaler, picks a source tick and divides it
// Assumes: source ticks are one-cycle pulses on clk_i
// Notes:   division counter is cleared while the timer is stopped
`timescale 1ns/1ps
module drdt_prescaler
   import drdt_pkg::*;
(
   // clock and reset
   input  wire logic       clk_i,
   input  wire logic       sys_rst_i,
   // source ticks
   input  wire logic       osc1_tick_i,
   input  wire logic       osc3_tick_i,
   // settings
   input  wire logic       run_i,
   input  wire logic       src_sel_i,
   input  wire logic [1:0] ratio_i,
   // divided tick
   output logic            tick_o
);
   logic [7:0] div_r;
   logic [7:0] mask;
   logic       src_tick;

   assign src_tick = src_sel_i ? osc3_tick_i : osc1_tick_i; // R17

   always_comb
   begin
      unique case (ratio_i) // R16
         2'b00: mask = DIV_MASK_0;
         2'b01: mask = DIV_MASK_1;
         2'b10: mask = DIV_MASK_2;
         2'b11: mask = DIV_MASK_3;
      endcase
   end

   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         div_r <= 8'h00;
      else if (!run_i)
         div_r <= 8'h00;
      else if (src_tick)
         div_r <= div_r + 8'h01;
   end

   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         tick_o <= 1'b0;
      else
         tick_o <= run_i && src_tick && ((div_r & mask) == mask); // R15 R16
   end

   AST_TICK_NEEDS_SOURCE: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      tick_o |-> $past(src_tick) && $past(run_i)) // R15
      else $error("prescaler tick without a source tick");
endmodule

// File: logic/drdt_event_filter.sv
// Purpose: noise rejector on the synchronised event level
// Assumes: f2k_fall_i pulses once per falling edge of the 2 kHz clock
// Notes:   bypassed when disabled, level then follows one cycle late
`timescale 1ns/1ps
module drdt_event_filter
   import drdt_pkg::*;
(
   // clock and reset
   input  wire logic clk_i,
   input  wire logic sys_rst_i,
   // inputs
   input  wire logic level_i,
   input  wire logic f2k_fall_i,
   input  wire logic enable_i,
   // filtered level
   output logic      level_o
);
   logic [1:0] falls_r;

   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         falls_r <= 2'b00;
      else if (level_i == level_o)
         falls_r <= 2'b00;
      else if (f2k_fall_i)
         falls_r <= falls_r + 2'b01;
   end

   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         level_o <= 1'b1;
      else if (!enable_i)
         level_o <= level_i;
      else if (level_i != level_o && f2k_fall_i
               && falls_r == 2'(FILTER_FALLS - 1))
         level_o <= level_i; // R12 R13
   end

   AST_FILTER_WAITS: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (enable_i && $past(enable_i) && $changed(level_o)) |-> $past(f2k_fall_i)) // R13
      else $error("filtered level changed off a 2 kHz falling edge");
endmodule

// File: logic/drdt_timer.sv
// Purpose: two 8-bit reload down timers, chainable to 16 bits
// Assumes: osc1, osc3 and event pin are slow asynchronous inputs
// Notes:   register read data stands one cycle after the read strobe
//
// How it works
// [R01] two 8-bit reload down counters, chainable
// [R02] chain off: timers run fully independently
// [R03] preset write copies reload into counter
// [R04] run gates count clock, stop holds value
// [R05] low read freezes high byte
// [R06] software reads low byte before high
// [R07] underflow reloads counter and keeps counting
// [R08] underflow drives flag, pulse, serial clock
// [R09] default prescaler source; timer 1 prescaler only
// [R10] event mode counts pin, ignores prescaler
// [R11] polarity: 0 falling, 1 rising edge
// [R12] filter bit inserts noise rejector
// [R13] accept change at second 2 kHz fall
// [R14] source holds each level 0.98 ms
// [R15] per-timer prescaler on chosen source
// [R16] ratio codes divide by 1,4,32,256
// [R17] source bit: 0 osc1, 1 osc3
// [R18] 16-bit: timer 0 low, run0 controls
// [R19] underflow sets flag; mask gates request
// [R20] event pin synchronised before edge detect
`timescale 1ns/1ps
module drdt_timer
   import drdt_pkg::*;
(
   // clock and reset
   input  wire logic          clk_i,
   input  wire logic          sys_rst_i,
   // register port
   input  wire logic [AW-1:0] reg_addr_i,
   input  wire logic [DW-1:0] reg_wdata_i,
   input  wire logic          reg_we_i,
   input  wire logic          reg_re_i,
   output logic      [DW-1:0] reg_rdata_o,
   // source clocks and event pin
   input  wire logic          osc1_i,
   input  wire logic          osc3_i,
   input  wire logic          event_input_pin_i,
   // outputs
   output logic               pulse_output_o,
   output logic               serial_clk_o,
   output logic               t0_irq_req_o,
   output logic               t1_irq_req_o
);
   logic [DW-1:0] ctrl_r;
   logic [DW-1:0] cfg0_r;
   logic [DW-1:0] cfg1_r;
   logic [DW-1:0] reload0_r;
   logic [DW-1:0] reload1_r;
   logic [DW-1:0] cnt0_r;
   logic [DW-1:0] cnt1_r;
   logic [DW-1:0] cnt0_nxt;
   logic [DW-1:0] cnt1_nxt;
   logic [DW-1:0] hold_r;
   logic          hold_vld_r;
   logic          t0_irq_flag_r;
   logic          t1_irq_flag_r;
   logic          t0_irq_mask_r;
   logic          t1_irq_mask_r;
   logic          pulse_output_r;
   logic [2:0]    osc1_s_r;
   logic [2:0]    osc3_s_r;
   logic [1:0]    ev_s_r;
   logic          ev_lvl;
   logic          ev_prev_r;
   logic [$clog2(F2K_DIV)-1:0] f2k_cnt_r;
   logic          osc1_tick;
   logic          osc3_tick;
   logic          f2k_fall;
   logic          pre0_tick;
   logic          pre1_tick;
   logic          ev_edge;
   logic          t0_clk;
   logic          t1_clk;
   logic          uf0;
   logic          uf1;
   logic          wr_ctrl;
   logic          t0_preset;
   logic          t1_preset;
   logic          t0_run;
   logic          t1_run;
   logic          chain_select;
   logic          t0_count_source_sel;
   logic          event_edge_polarity;
   logic          event_filter_sel;
   logic          pulse_output_sel_uf;
   logic          t1_active;

   assign t0_run              = ctrl_r[B_T0_RUN];
   assign t1_run              = ctrl_r[B_T1_RUN];
   assign chain_select        = ctrl_r[B_CHAIN];
   assign t0_count_source_sel = cfg0_r[B_CNT_SRC];
   assign event_edge_polarity = cfg0_r[B_EDGE_POL];
   assign event_filter_sel    = cfg0_r[B_FILTER];
   assign wr_ctrl             = reg_we_i && (reg_addr_i == ADR_CTRL);
   assign t0_preset           = wr_ctrl && reg_wdata_i[B_T0_PRESET];
   assign t1_preset           = wr_ctrl && reg_wdata_i[B_T1_PRESET];

   // source clock and event pin synchronisers
   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         osc1_s_r <= 3'b000;
         osc3_s_r <= 3'b000;
         ev_s_r   <= 2'b11;
      end
      else
      begin
         osc1_s_r <= {osc1_s_r[1:0], osc1_i};
         osc3_s_r <= {osc3_s_r[1:0], osc3_i};
         ev_s_r   <= {ev_s_r[0], event_input_pin_i}; // R20
      end
   end

   assign osc1_tick = osc1_s_r[1] && !osc1_s_r[2];
   assign osc3_tick = osc3_s_r[1] && !osc3_s_r[2];

   // 2 kHz clock from osc1; its falling edge is the counter wrap
   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         f2k_cnt_r <= '0;
      else if (osc1_tick)
         f2k_cnt_r <= f2k_cnt_r + 1'b1;
   end

   assign f2k_fall = osc1_tick && (f2k_cnt_r == '1);

   drdt_prescaler u_pre0 (
      .clk_i       (clk_i),
      .sys_rst_i   (sys_rst_i),
      .osc1_tick_i (osc1_tick),
      .osc3_tick_i (osc3_tick),
      .run_i       (t0_run && !t0_count_source_sel),
      .src_sel_i   (cfg0_r[B_SRC_SEL]),
      .ratio_i     (cfg0_r[B_RATIO_HI:B_RATIO_LO]),
      .tick_o      (pre0_tick)
   );

   drdt_prescaler u_pre1 (
      .clk_i       (clk_i),
      .sys_rst_i   (sys_rst_i),
      .osc1_tick_i (osc1_tick),
      .osc3_tick_i (osc3_tick),
      .run_i       (t1_run && !chain_select),
      .src_sel_i   (cfg1_r[B_SRC_SEL]),
      .ratio_i     (cfg1_r[B_RATIO_HI:B_RATIO_LO]),
      .tick_o      (pre1_tick)
   );

   drdt_event_filter u_filt (
      .clk_i      (clk_i),
      .sys_rst_i  (sys_rst_i),
      .level_i    (ev_s_r[1]),
      .f2k_fall_i (f2k_fall),
      .enable_i   (event_filter_sel),
      .level_o    (ev_lvl)
   );

   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         ev_prev_r <= 1'b1;
      else
         ev_prev_r <= ev_lvl;
   end

   assign ev_edge = event_edge_polarity ? (ev_lvl && !ev_prev_r)
                                        : (!ev_lvl && ev_prev_r); // R11
   assign t0_clk  = t0_run && (t0_count_source_sel ? ev_edge : pre0_tick); // R04 R09 R10
   assign t1_clk  = !chain_select && t1_run && pre1_tick; // R02 R09

   // counter next state, chained or separate
   always_comb
   begin
      cnt0_nxt = cnt0_r;
      cnt1_nxt = cnt1_r;
      uf0      = 1'b0;
      uf1      = 1'b0;
      if (chain_select)
      begin
         if (t0_clk) // R18
         begin
            uf0 = (cnt0_r == 8'h00);
            if ({cnt1_r, cnt0_r} == 16'h0000)
            begin
               cnt0_nxt = reload0_r; // R07
               cnt1_nxt = reload1_r;
               uf1      = 1'b1;
            end
            else
               {cnt1_nxt, cnt0_nxt} = {cnt1_r, cnt0_r} - 16'h0001;
         end
      end
      else
      begin
         if (t0_clk) // R01 R02
         begin
            uf0      = (cnt0_r == 8'h00);
            cnt0_nxt = uf0 ? reload0_r : cnt0_r - 8'h01; // R07
         end
         if (t1_clk)
         begin
            uf1      = (cnt1_r == 8'h00);
            cnt1_nxt = uf1 ? reload1_r : cnt1_r - 8'h01; // R07
         end
      end
      if (t0_preset)
         cnt0_nxt = reload0_r; // R03
      if (t1_preset)
         cnt1_nxt = reload1_r; // R03
   end

   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         cnt0_r <= RST_COUNT;
         cnt1_r <= RST_COUNT;
      end
      else
      begin
         cnt0_r <= cnt0_nxt;
         cnt1_r <= cnt1_nxt;
      end
   end

   // software registers
   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         ctrl_r        <= RST_REG;
         cfg0_r        <= RST_REG;
         cfg1_r        <= RST_REG;
         reload0_r     <= RST_REG;
         reload1_r     <= RST_REG;
         t0_irq_mask_r <= 1'b0;
         t1_irq_mask_r <= 1'b0;
      end
      else if (reg_we_i)
      begin
         unique case (reg_addr_i)
            ADR_CTRL:    ctrl_r    <= reg_wdata_i & 8'h73;
            ADR_CFG0:    cfg0_r    <= reg_wdata_i & 8'h3F;
            ADR_CFG1:    cfg1_r    <= reg_wdata_i & 8'h07;
            ADR_RELOAD0: reload0_r <= reg_wdata_i;
            ADR_RELOAD1: reload1_r <= reg_wdata_i;
            ADR_IRQ:
            begin
               t0_irq_mask_r <= reg_wdata_i[B_T0_MASK];
               t1_irq_mask_r <= reg_wdata_i[B_T1_MASK];
            end
            default: ;
         endcase
      end
   end

   // flags: a new underflow wins over a write-one clear
   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         t0_irq_flag_r <= 1'b0;
         t1_irq_flag_r <= 1'b0;
      end
      else
      begin
         if (uf0)
            t0_irq_flag_r <= 1'b1; // R08 R19
         else if (reg_we_i && reg_addr_i == ADR_IRQ && reg_wdata_i[B_T0_FLAG])
            t0_irq_flag_r <= 1'b0;
         if (uf1)
            t1_irq_flag_r <= 1'b1; // R08 R19
         else if (reg_we_i && reg_addr_i == ADR_IRQ && reg_wdata_i[B_T1_FLAG])
            t1_irq_flag_r <= 1'b0;
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         t0_irq_req_o <= 1'b0;
         t1_irq_req_o <= 1'b0;
      end
      else
      begin
         t0_irq_req_o <= t0_irq_flag_r && t0_irq_mask_r; // R19
         t1_irq_req_o <= t1_irq_flag_r && t1_irq_mask_r;
      end
   end

   // high byte hold and read data
   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         hold_r     <= RST_COUNT;
         hold_vld_r <= 1'b0;
      end
      else if (reg_re_i && reg_addr_i == ADR_COUNT0)
      begin
         hold_r     <= cnt1_r; // R05 R06
         hold_vld_r <= 1'b1;
      end
      else if (reg_re_i && reg_addr_i == ADR_COUNT1)
         hold_vld_r <= 1'b0;
   end

   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         reg_rdata_o <= 8'h00;
      else if (reg_re_i)
      begin
         unique case (reg_addr_i)
            ADR_CTRL:    reg_rdata_o <= ctrl_r;
            ADR_CFG0:    reg_rdata_o <= cfg0_r;
            ADR_CFG1:    reg_rdata_o <= cfg1_r;
            ADR_RELOAD0: reg_rdata_o <= reload0_r;
            ADR_RELOAD1: reg_rdata_o <= reload1_r;
            ADR_COUNT0:  reg_rdata_o <= cnt0_r;
            ADR_COUNT1:  reg_rdata_o <= hold_vld_r ? hold_r : cnt1_r; // R05
            ADR_IRQ:     reg_rdata_o <= {4'h0, t1_irq_mask_r, t0_irq_mask_r,
                                         t1_irq_flag_r, t0_irq_flag_r};
            default:     reg_rdata_o <= 8'h00;
         endcase
      end
      else
         reg_rdata_o <= 8'h00;
   end

   // pulse output and serial clock, each a divide-by-two of underflows
   assign pulse_output_sel_uf = ctrl_r[B_PULSE_OUTPUT_CH] ? uf1 : uf0;
   assign t1_active   = chain_select ? t0_run : t1_run;

   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         pulse_output_r         <= 1'b0;
         pulse_output_o <= 1'b1;
      end
      else
      begin
         if (pulse_output_sel_uf)
            pulse_output_r <= !pulse_output_r; // R08
         pulse_output_o <= ctrl_r[B_PULSE_OUTPUT_EN] ? pulse_output_r : 1'b1;
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         serial_clk_o <= 1'b0;
      else if (!t1_active)
         serial_clk_o <= 1'b0;
      else if (uf1)
         serial_clk_o <= !serial_clk_o; // R08
   end

   sequence s_preset0;
      t0_preset;
   endsequence

   AST_PRESET_LOADS: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R03
      s_preset0 |=> cnt0_r == $past(reload0_r))
      else $error("preset did not load reload value");
   AST_STOP_HOLDS: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R04
      (!t0_run && !t0_preset && !t1_preset) |=> $stable(cnt0_r))
      else $error("stopped timer 0 changed");
   AST_RELOAD_ON_UF: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R07
      (!chain_select && t0_clk && cnt0_r == 8'h00 && !t0_preset)
      |=> cnt0_r == $past(reload0_r))
      else $error("underflow did not reload");
   AST_FLAG_SET: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R19
      uf1 |=> t1_irq_flag_r ##1 (t1_irq_req_o == $past(t1_irq_mask_r)))
      else $error("underflow flag or request wrong");
   AST_HOLD_HIGH: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R05
      (reg_re_i && reg_addr_i == ADR_COUNT0) ##1 (reg_re_i && reg_addr_i == ADR_COUNT1)
      |=> reg_rdata_o == $past(cnt1_r, 2))
      else $error("high byte not held after low read");
   AST_EVENT_ONLY: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R10
      (t0_count_source_sel && !ev_edge && !t0_preset && !t1_preset) |=> $stable(cnt0_r))
      else $error("event mode counted without edge");
   AST_T1_PRESCALER: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R09
      (!chain_select && !pre1_tick && !t1_preset) |=> $stable(cnt1_r))
      else $error("timer 1 counted without prescaler tick");
   AST_CHAIN_BORROW: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R18
      (chain_select && t0_clk && cnt0_r != 8'h00 && !t0_preset && !t1_preset)
      |=> $stable(cnt1_r) && cnt0_r == $past(cnt0_r) - 8'h01)
      else $error("chained low byte step wrong");
   AST_POLARITY: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R11
      (t0_run && t0_count_source_sel && $rose(ev_lvl) && !event_edge_polarity
       && !t0_preset && !t1_preset) |=> $stable(cnt0_r))
      else $error("falling polarity counted a rising edge");
endmodule

// File: dv/drdt_pulse_src.sv
// Purpose: external pulse source that drives the event pin
// Assumes: each start asks for a number of level toggles
// Notes:   the pin idles high and keeps the level it drove last
`timescale 1ns/1ps
module drdt_pulse_src
(
   // clock
   input  wire logic        clk_i,
   // request
   input  wire logic        start_i,
   input  wire logic [3:0]  toggles_i,
   input  wire logic [15:0] hold_i,
   // pin side
   output logic             pin_o,
   output logic             busy_o
);
   logic        pin_r  = 1'b1;
   logic        busy_r = 1'b0;
   logic [3:0]  left_r = 4'h0;
   logic [15:0] cnt_r  = 16'h0000;
   logic [15:0] hold_r = 16'h0000;

   assign pin_o  = pin_r;
   assign busy_o = busy_r;

   // every level stands hold_i+1 cycles before the next toggle
   always @(posedge clk_i)
   begin
      if (start_i && !busy_r)
      begin
         busy_r <= 1'b1;
         left_r <= toggles_i;
         hold_r <= hold_i;
         cnt_r  <= 16'h0000;
      end
      else if (busy_r && cnt_r != 16'h0000)
      begin
         cnt_r <= cnt_r - 16'h0001;
      end
      else if (busy_r && left_r == 4'h0)
      begin
         busy_r <= 1'b0;
      end
      else if (busy_r)
      begin
         pin_r  <= ~pin_r;
         left_r <= left_r - 4'h1;
         cnt_r  <= hold_r;
      end
   end
endmodule

// File: dv/testbench.sv
// Purpose: self-checking bench of the dual reload down timer
// Assumes: osc1 period 8 cycles, osc3 period 4 cycles
// Notes:   periods are measured between pulse output toggles
`timescale 1ns/1ps
module testbench
   import drdt_pkg::*;
;
   logic          clk     = 1'b0;
   logic          sys_rst = 1'b1;
   logic          we      = 1'b0;
   logic          re      = 1'b0;
   logic [AW-1:0] addr    = '0;
   logic [DW-1:0] wdata   = '0;
   logic [DW-1:0] rdata;
   logic [DW-1:0] rd_v;
   logic          osc1    = 1'b0;
   logic          osc3    = 1'b0;
   logic [31:0]   cyc     = '0;
   logic          pstart  = 1'b0;
   logic [3:0]    tg      = 4'h0;
   logic [15:0]   hold    = 16'h0000;
   logic          pin;
   logic          pbusy;
   logic          pout;
   logic          sclk;
   logic          irq0;
   logic          irq1;
   int            miscompares = 0;
   int            compares    = 0;

   drdt_timer dut (.clk_i(clk), .sys_rst_i(sys_rst), .reg_addr_i(addr), .reg_wdata_i(wdata),
      .reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rdata), .osc1_i(osc1), .osc3_i(osc3),
      .event_input_pin_i(pin), .pulse_output_o(pout), .serial_clk_o(sclk),
      .t0_irq_req_o(irq0), .t1_irq_req_o(irq1));
   drdt_pulse_src src (.clk_i(clk), .start_i(pstart), .toggles_i(tg), .hold_i(hold),
      .pin_o(pin), .busy_o(pbusy));

   initial
   begin
      forever #5 clk = ~clk;
   end

   always @(posedge clk)
   begin
      cyc  <= cyc + 1;
      osc1 <= cyc[2];
      osc3 <= cyc[1];
   end

   function automatic int per(input int code, input int s, input int r);
      return (r + 1) * (code == 0 ? 1 : code == 1 ? 4 : code == 2 ? 32 : 256) * (s ? 4 : 8);
   endfunction

   function automatic int edges(input logic st, input int k, input logic pol);
      return (st ^ pol) ? (k + 1) / 2 : k / 2;
   endfunction

   task tally_and_finish();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      compares++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
      @(posedge clk);
      we    <= 1'b1;
      addr  <= a;
      wdata <= d;
      @(posedge clk);
      we    <= 1'b0;
   endtask

   task rd(input logic [AW-1:0] a);
      @(posedge clk);
      re   <= 1'b1;
      addr <= a;
      @(posedge clk);
      re   <= 1'b0;
      #1 rd_v = rdata;
   endtask

   task wait_tog(output logic [31:0] at);
      logic o;
      int   n;
      o = pout;
      n = 0;
      do
      begin
         @(posedge clk);
         #1 n++;
      end
      while (pout === o && n < 10000);
      at = cyc;
   endtask

   task pulses(input int k, input int h);
      int n;
      n = 0;
      @(posedge clk);
      tg     <= 4'(k);
      hold   <= 16'(h);
      pstart <= 1'b1;
      @(posedge clk);
      pstart <= 1'b0;
      do
      begin
         @(posedge clk);
         #1 n++;
      end
      while (pbusy === 1'b1 && n < 5000);
   endtask

   // span covers the slowest prescaler periods with margin
   initial
   begin
      repeat (90000) @(posedge clk);
      miscompares++;
      tally_and_finish();
   end

   initial
   begin
      logic [7:0]  v;
      logic [7:0]  r;
      logic [7:0]  c1;
      logic [31:0] t_a;
      logic [31:0] t_b;
      logic        s0;
      logic        s;
      logic        pol;
      logic        f;
      logic        st;
      int          k;
      void'($urandom(35844));
      repeat (12) @(posedge clk);
      sys_rst <= 1'b0;
      #1 chk({pout, sclk, irq1, irq0}, 4'h8, "outputs after reset");
      for (int a = 0; a < 16; a++)
      begin
         rd(AW'(a));
         chk(rd_v, RST_REG, "reset value");
      end
      for (int a = 1; a < 16; a++)
      begin
         v = 8'($urandom);
         wr(AW'(a), v);
         rd(AW'(a));
         chk(rd_v, a == 1 ? v & 8'h3F : a == 2 ? v & 8'h07 : a == 7 ? v & 8'h0C :
             a < 5 ? v : 8'h00, "register mask");
      end
      v = 8'($urandom);
      wr(ADR_CTRL, v);
      rd(ADR_CTRL);
      chk(rd_v, v & 8'h73, "ctrl mask");
      wr(ADR_CTRL, 8'h00);
      r = 8'h40 | 8'($urandom);
      wr(ADR_RELOAD0, r);
      wr(ADR_CFG0, 8'h04);
      wr(ADR_CTRL, 8'h04);
      repeat (40) @(posedge clk);
      rd(ADR_COUNT0);
      chk(rd_v, r, "preset count");
      wr(ADR_CTRL, 8'h01);
      repeat (40) @(posedge clk);
      wr(ADR_CTRL, 8'h00);
      rd(ADR_COUNT0);
      c1 = rd_v;
      chk(c1 < r, 1'b1, "counted down");
      repeat (100) @(posedge clk);
      rd(ADR_COUNT0);
      chk(rd_v, c1, "held while stopped");
      wr(ADR_CTRL, 8'h01);
      repeat (40) @(posedge clk);
      wr(ADR_CTRL, 8'h00);
      rd(ADR_COUNT0);
      chk(rd_v < c1, 1'b1, "resumed count");
      wr(ADR_RELOAD0, 8'h10);
      wr(ADR_RELOAD1, 8'h01);
      wr(ADR_CTRL, 8'h1C);
      wr(ADR_CTRL, 8'h11);
      rd(ADR_COUNT0);
      repeat (120) @(posedge clk);
      rd(ADR_COUNT1);
      chk(rd_v, 8'h01, "frozen high byte");
      rd(ADR_COUNT1);
      chk(rd_v, 8'h00, "chained borrow");
      // back-to-back low then high read: the high byte comes from the hold
      @(posedge clk);
      re   <= 1'b1;
      addr <= ADR_COUNT0;
      @(posedge clk);
      addr <= ADR_COUNT1;
      @(posedge clk);
      re   <= 1'b0;
      #1 chk(rdata, 8'h00, "back to back high byte");
      wr(ADR_IRQ, 8'h0C);
      for (int t = 0; t < 2; t++)
      begin
         for (int code = 0; code < 4; code++)
         begin
            s = 1'($urandom);
            r = (code == 3) ? 8'($urandom % 2) : 8'($urandom % 4);
            wr(t ? ADR_CFG1 : ADR_CFG0, {5'h00, s, 2'(code)});
            wr(t ? ADR_RELOAD1 : ADR_RELOAD0, r);
            wr(ADR_CTRL, t ? 8'h6A : 8'h45);
            wait_tog(t_a);
            wait_tog(t_a);
            s0 = sclk;
            wait_tog(t_b);
            chk(t_b - t_a, per(code, s, r), "underflow period");
            chk(sclk, t ? !s0 : 1'b0, "serial clock");
            chk(t ? irq1 : irq0, 1'b1, "irq request");
         end
      end
      wr(ADR_CTRL, 8'h00);
      wr(ADR_IRQ, 8'h03);
      wr(ADR_CFG0, 8'h04);
      wr(ADR_RELOAD0, 8'h00);
      wr(ADR_CTRL, 8'h05);
      repeat (40) @(posedge clk);
      chk(irq0, 1'b0, "masked request");
      rd(ADR_IRQ);
      chk(rd_v, 8'h01, "flag despite mask");
      wr(ADR_CTRL, 8'h00);
      wr(ADR_IRQ, 8'h01);
      rd(ADR_IRQ);
      chk(rd_v, 8'h00, "flag cleared");
      wr(ADR_RELOAD0, 8'hFF);
      for (int i = 0; i < 5; i++)
      begin
         pol = i[0];
         f = i[1] | i[2];
         k = (i == 4) ? 2 : 1 + 2 * ($urandom % 3);
         wr(ADR_CFG0, {2'b00, f, pol, 1'b1, 3'($urandom)});
         wr(ADR_CTRL, 8'h05);
         st = pin;
         pulses(k, i == 4 ? 60 : f ? 300 : 10);
         repeat (f ? 400 : 20) @(posedge clk);
         rd(ADR_COUNT0);
         chk(rd_v, i == 4 ? 8'hFF : 8'hFF - edges(st, k, pol), "event count");
         if (pin === 1'b0)
            pulses(1, f ? 300 : 10);
         repeat (f ? 400 : 20) @(posedge clk);
      end
      tally_and_finish();
   end
endmodule
